/* File: mubsp_pkg.sv */
// constants for the muxed utility bus and status pin block
package mubsp_pkg;
  localparam int NPORTS = 4;
  localparam int MEM_DEPTH = 256;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h01;
  localparam logic [7:0] ADDR_INT_MASK = 8'h02;
  localparam logic [7:0] ADDR_MARKER_PORT = 8'h40;
  localparam logic [7:0] ADDR_MARKER_LEN = 8'h41;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] MARKER_PORT_RST = 2'h0;
  localparam logic [7:0] MARKER_LEN_RST = 8'h08;
  // indicator low time in line cycles (223)
  localparam logic [7:0] IND_CYCLES = 8'hdf;
  localparam logic [1:0] MODE_UTOPIA2 = 2'h0;
  localparam logic [1:0] MODE_UTOPIA1 = 2'h1;
  localparam logic [1:0] MODE_DPI = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  // sync vector bit positions
  localparam int SY_ALE = 3;
  localparam int SY_RD = 2;
  localparam int SY_WR = 1;
  localparam int SY_CS = 0;
endpackage

/* File: mubsp_mem_if.sv */
// interface between the bus logic and the general register memory
`timescale 1ns/1ps
interface mubsp_mem_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface

/* File: mubsp_regmem.sv */
// general register memory with registered read data
`timescale 1ns/1ps
module mubsp_regmem #(
  parameter int DEPTH = mubsp_pkg::MEM_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  mubsp_mem_if.mem bus
);
  typedef struct packed {
    logic [7:0] rdata;
  } mubsp_mem_state_t;

  logic [7:0] mem_q [DEPTH];
  mubsp_mem_state_t s_q;
  mubsp_mem_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdata = mem_q[bus.addr];
  end

  // array has no reset; contents are undefined until software writes them
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rdata = s_q.rdata;
endmodule

/* File: mubsp_top.sv */
// utility bus slave, interrupt pin, mode decode, indicators and marker output
`timescale 1ns/1ps
module mubsp_top #(
  parameter int NPORTS = mubsp_pkg::NPORTS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] int_event,
  output logic int_out,
  output logic int_oe,
  input wire logic [1:0] mode,
  output logic [3:0] cell_if_sel,
  input wire logic [NPORTS-1:0] receive_cell_start,
  input wire logic [NPORTS-1:0] receive_cell_good,
  input wire logic [NPORTS-1:0] marker_received,
  output logic [NPORTS-1:0] receive_indicator_n,
  output logic receive_marker_pulse_n,
  input wire logic [NPORTS-1:0] line_rx_p,
  input wire logic [NPORTS-1:0] line_rx_n,
  output logic [NPORTS-1:0] line_rx_data,
  input wire logic [NPORTS-1:0] line_tx_data,
  output logic [NPORTS-1:0] line_tx_p,
  output logic [NPORTS-1:0] line_tx_n,
  input wire logic tie_low_a,
  input wire logic tie_low_b,
  input wire logic tie_low_c
);
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] status;
    logic [1:0] mport;
    logic [7:0] mlen;
    logic [7:0] mcnt;
    logic [NPORTS-1:0][7:0] icnt;
    logic [NPORTS-1:0] ind_n;
    logic ref_n;
    logic int_out;
    logic int_oe;
    logic ad_oe;
    logic [7:0] ad_out;
    logic [3:0] if_sel;
    logic [NPORTS-1:0] rx_data;
    logic [NPORTS-1:0] tx_p;
    logic [NPORTS-1:0] tx_n;
  } mubsp_state_t;

  mubsp_state_t s_q;
  mubsp_state_t s_d;
  mubsp_mem_if mem_bus ();

  logic rd_act;
  logic rd_prev;
  logic rd_start;
  logic wr_act;
  logic wr_prev;
  logic wr_end;
  logic ale_fall;
  logic marker_hit;
  logic [7:0] rd_mux;

  function automatic logic [3:0] mubsp_mode_dec(input logic [1:0] m);
    case (m)
      mubsp_pkg::MODE_UTOPIA2: mubsp_mode_dec = 4'h1;
      mubsp_pkg::MODE_UTOPIA1: mubsp_mode_dec = 4'h2;
      mubsp_pkg::MODE_DPI: mubsp_mode_dec = 4'h4;
      default: mubsp_mode_dec = 4'h8;
    endcase
  endfunction

  // strobe decode on synchronised copies only
  assign rd_act = !s_q.sync2[mubsp_pkg::SY_RD] && !s_q.sync2[mubsp_pkg::SY_CS];
  assign rd_prev = !s_q.sync3[mubsp_pkg::SY_RD] && !s_q.sync3[mubsp_pkg::SY_CS];
  assign rd_start = rd_act && !rd_prev;
  assign wr_act = !s_q.sync2[mubsp_pkg::SY_WR] && !s_q.sync2[mubsp_pkg::SY_CS];
  assign wr_prev = !s_q.sync3[mubsp_pkg::SY_WR] && !s_q.sync3[mubsp_pkg::SY_CS];
  assign wr_end = wr_prev && !wr_act;
  assign ale_fall = s_q.sync3[mubsp_pkg::SY_ALE] && !s_q.sync2[mubsp_pkg::SY_ALE];
  assign marker_hit = marker_received[s_q.mport];

  always_comb begin
    case (s_q.addr)
      mubsp_pkg::ADDR_INT_STATUS: rd_mux = s_q.status;
      mubsp_pkg::ADDR_INT_MASK: rd_mux = s_q.mask;
      mubsp_pkg::ADDR_MARKER_PORT: rd_mux = {6'h00, s_q.mport};
      mubsp_pkg::ADDR_MARKER_LEN: rd_mux = s_q.mlen;
      default: rd_mux = mem_bus.rdata;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {ale, rd_n, wr_n, cs_n};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    if (ale_fall) begin
      s_d.addr = ad_in;
    end
    if (wr_end) begin
      case (s_q.addr)
        mubsp_pkg::ADDR_INT_MASK: s_d.mask = ad_in;
        mubsp_pkg::ADDR_MARKER_PORT: s_d.mport = ad_in[1:0];
        mubsp_pkg::ADDR_MARKER_LEN: s_d.mlen = ad_in;
        default: ;
      endcase
    end
    // read value is frozen at the start of the read so a clear cannot change it
    if (rd_start) begin
      s_d.ad_out = rd_mux;
    end
    s_d.ad_oe = rd_act;
    // a new event in the clearing cycle survives the clear
    if (rd_start && s_q.addr == mubsp_pkg::ADDR_INT_STATUS) begin
      s_d.status = int_event;
    end else begin
      s_d.status = s_q.status | int_event;
    end
    // open-drain data level; only the enable ever moves
    s_d.int_out = 1'b0;
    s_d.int_oe = |(s_q.status & s_q.mask);
    s_d.if_sel = mubsp_mode_dec(mode);
    for (int i = 0; i < NPORTS; i++) begin
      if (receive_cell_start[i] && receive_cell_good[i]) begin
        s_d.icnt[i] = mubsp_pkg::IND_CYCLES;
      end else if (s_q.icnt[i] != 8'h00) begin
        s_d.icnt[i] = s_q.icnt[i] - 8'h01;
      end
      s_d.ind_n[i] = (s_d.icnt[i] == 8'h00);
    end
    if (marker_hit && s_q.ref_n) begin
      s_d.mcnt = (s_q.mlen == 8'h00) ? 8'h01 : s_q.mlen;
    end else if (s_q.mcnt != 8'h00) begin
      s_d.mcnt = s_q.mcnt - 8'h01;
    end
    s_d.ref_n = (s_d.mcnt == 8'h00);
    s_d.rx_data = line_rx_p & ~line_rx_n;
    s_d.tx_p = line_tx_data;
    s_d.tx_n = ~line_tx_data;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.sync1 <= 4'hf;
      s_q.sync2 <= 4'hf;
      s_q.sync3 <= 4'hf;
      s_q.mask <= mubsp_pkg::MASK_RST;
      s_q.mport <= mubsp_pkg::MARKER_PORT_RST;
      s_q.mlen <= mubsp_pkg::MARKER_LEN_RST;
      s_q.ind_n <= '1;
      s_q.ref_n <= 1'b1;
      s_q.if_sel <= 4'h1;
      s_q.tx_n <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_bus.wr_en = wr_end && (s_q.addr != mubsp_pkg::ADDR_INT_STATUS) &&
    (s_q.addr != mubsp_pkg::ADDR_INT_MASK) && (s_q.addr != mubsp_pkg::ADDR_MARKER_PORT) &&
    (s_q.addr != mubsp_pkg::ADDR_MARKER_LEN);
  assign mem_bus.addr = s_q.addr;
  assign mem_bus.wdata = ad_in;

  mubsp_regmem #(
    .DEPTH(mubsp_pkg::MEM_DEPTH)
  ) u_regmem (
    .clk(clk),
    .rstn(rstn),
    .bus(mem_bus)
  );

  assign ad_out = s_q.ad_out;
  assign ad_oe = s_q.ad_oe;
  assign int_out = s_q.int_out;
  assign int_oe = s_q.int_oe;
  assign cell_if_sel = s_q.if_sel;
  assign receive_indicator_n = s_q.ind_n;
  assign receive_marker_pulse_n = s_q.ref_n;
  assign line_rx_data = s_q.rx_data;
  assign line_tx_p = s_q.tx_p;
  assign line_tx_n = s_q.tx_n;

  // reserved straps have no function
  logic unused_ties;
  assign unused_ties = tie_low_a ^ tie_low_b ^ tie_low_c;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_addr_latch: assert property (ale_fall |=> s_q.addr == $past(ad_in))
    else $error("address not taken on address latch fall");
  a_sync_delay: assert property ($fell(ale) |=> s_q.addr == $past(s_q.addr))
    else $error("address taken before strobe synchronised");
  a_read_drive: assert property (ad_oe |-> $past(rd_act))
    else $error("bus driven outside a read");
  a_read_release: assert property (!rd_act |=> !ad_oe)
    else $error("bus still driven after read");
  a_write_take: assert property (wr_end && s_q.addr == mubsp_pkg::ADDR_INT_MASK
    |=> s_q.mask == $past(ad_in))
    else $error("mask write lost");
  a_int_assert: assert property ((s_q.status & s_q.mask) != 8'h00 |=> int_oe)
    else $error("interrupt pin not pulled low");
  a_int_masked: assert property ((s_q.status & s_q.mask) == 8'h00 |=> !int_oe)
    else $error("masked source drives interrupt");
  a_int_clear: assert property (rd_start && s_q.addr == mubsp_pkg::ADDR_INT_STATUS
    |=> s_q.status == $past(int_event))
    else $error("status not cleared by read");
  a_mode_dpi: assert property (mode == mubsp_pkg::MODE_DPI |=> cell_if_sel == 4'h4)
    else $error("mode decode wrong");
  a_marker_pulse: assert property (marker_hit && receive_marker_pulse_n
    |=> !receive_marker_pulse_n)
    else $error("marker pulse missing");

  for (genvar g = 0; g < NPORTS; g++) begin : g_ind_chk
    a_ind_start: assert property (receive_cell_start[g] && receive_cell_good[g]
      |=> !receive_indicator_n[g] [*8])
      else $error("indicator did not go low");
    a_ind_length: assert property ($fell(receive_indicator_n[g])
      |-> ##222 !receive_indicator_n[g])
      else $error("indicator released early");
    a_ind_end: assert property (!receive_indicator_n[g] && s_q.icnt[g] == 8'h01
      && !(receive_cell_start[g] && receive_cell_good[g]) |=> receive_indicator_n[g])
      else $error("indicator held too long");
  end

  // address register only moves on a latch fall
  a_addr_hold: assert property (!ale_fall |=> s_q.addr == $past(s_q.addr))
    else $error("address changed without latch fall");
  // read data must not move while the bus is driven
  a_read_stable: assert property (ad_oe && $past(ad_oe) |-> $stable(ad_out))
    else $error("read data changed during read");
  // every event sets its status bit, even in a clearing cycle
  a_status_set: assert property (int_event != 8'h00
    |=> (s_q.status & $past(int_event)) == $past(int_event))
    else $error("event not recorded in status");
  // status bits stay set until a status read
  a_status_keep: assert property (!(rd_start && s_q.addr == mubsp_pkg::ADDR_INT_STATUS)
    |=> (s_q.status & $past(s_q.status)) == $past(s_q.status))
    else $error("status bit lost without read");
  a_mode_u2: assert property (mode == mubsp_pkg::MODE_UTOPIA2 |=> cell_if_sel == 4'h1)
    else $error("mode decode wrong for level 2");
  a_mode_u1: assert property (mode == mubsp_pkg::MODE_UTOPIA1 |=> cell_if_sel == 4'h2)
    else $error("mode decode wrong for level 1");
  a_mode_rsvd: assert property (mode == mubsp_pkg::MODE_RSVD |=> cell_if_sel == 4'h8)
    else $error("mode decode wrong for reserved code");
  // a pulse in progress ignores further markers and runs to its end
  a_marker_hold: assert property (s_q.mcnt > 8'h01 |=> !receive_marker_pulse_n)
    else $error("marker pulse ended early");
  a_marker_end: assert property (s_q.mcnt == 8'h01 |=> receive_marker_pulse_n)
    else $error("marker pulse too long");
  // transmit pair is always complementary
  a_tx_pair: assert property (line_tx_n == ~line_tx_p)
    else $error("transmit pair not complementary");

  c_ind: cover property ($fell(receive_indicator_n[0]));
  c_read: cover property (rd_start ##[1:8] !rd_act);
  c_write: cover property (wr_end);
  c_marker: cover property (marker_hit ##1 !receive_marker_pulse_n);
  c_int: cover property (int_oe ##1 rd_start);
endmodule

/* File: mubsp_host.sv */
// host model that drives the muxed utility bus
`timescale 1ns/1ps
module mubsp_host (
  input wire logic clk,
  input wire logic ad_oe,
  input wire logic [7:0] ad_out,
  output logic [7:0] host_ad,
  output logic ale,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n
);
  initial begin
    host_ad = 8'h00;
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put_addr(input logic [7:0] a);
    host_ad = a;
    ale = 1'b1;
    tick(4);
    ale = 1'b0;
    tick(4);
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    put_addr(a);
    host_ad = d;
    tick(1);
    wr_n = 1'b0;
    cs_n = 1'b0;
    tick(4);
    wr_n = 1'b1;
    cs_n = 1'b1;
    tick(4);
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    int n;
    put_addr(a);
    // released bus shows a changed value, never the stale one
    host_ad = ~host_ad;
    rd_n = 1'b0;
    cs_n = 1'b0;
    n = 0;
    // look just after the edge so the freshly launched enable is settled
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ad_oe !== 1'b1 && n < 12);
    d = (ad_oe === 1'b1) ? ad_out : 8'hxx;
    tick(1);
    rd_n = 1'b1;
    cs_n = 1'b1;
    tick(5);
  endtask
endmodule

/* File: mubsp_top_test.sv */
// self-checking testbench for the utility bus and status pin block
`timescale 1ns/1ps
module mubsp_top_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] int_event = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [3:0] cst = 4'h0, cgd = 4'h0, mrk = 4'h0, rxp = 4'h0, rxn = 4'h0, txd = 4'h0;
  logic [7:0] host_ad, ad_out, d, a;
  logic ad_oe, ale, cs_n, rd_n, wr_n, int_out, int_oe, rmp;
  logic [3:0] sel, ind, rxd, txp, txn;
  int mismatches = 0, comparisons = 0, psel = 0, n, stat = 0, mask = 0, p;
  int mem[int];
  int lens[3];
  wire [7:0] ad_in = ad_oe ? ad_out : host_ad;
  wire probe = (psel == 4) ? rmp : ind[psel];
  always #10 clk = ~clk;
  mubsp_host host (.clk(clk), .ad_oe(ad_oe), .ad_out(ad_out), .host_ad(host_ad), .ale(ale),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
  mubsp_top uut (.clk(clk), .rstn(rstn), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .int_event(int_event),
    .int_out(int_out), .int_oe(int_oe), .mode(mode), .cell_if_sel(sel),
    .receive_cell_start(cst), .receive_cell_good(cgd), .marker_received(mrk),
    .receive_indicator_n(ind), .receive_marker_pulse_n(rmp), .line_rx_p(rxp),
    .line_rx_n(rxn), .line_rx_data(rxd), .line_tx_data(txd), .line_tx_p(txp),
    .line_tx_n(txn), .tie_low_a(1'b0), .tie_low_b(1'b0), .tie_low_c(1'b0));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_len(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] %0t len %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [3:0] s, input logic [3:0] g, input logic [3:0] m);
    cst = s;
    cgd = g;
    mrk = m;
    tick(1);
    {cst, cgd, mrk} = 12'h000;
  endtask
  task automatic measure(output int k);
    k = 0;
    while (probe === 1'b0 && k < 400) begin
      tick(1);
      k++;
    end
  endtask
  task automatic event_in(input logic [7:0] e);
    int_event = e;
    tick(1);
    int_event = 8'h00;
    stat |= e;
    tick(3);
    chk_val({7'h0, int_oe}, {7'h0, (stat & mask) != 0});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(58));
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    tick(2);
    chk_val({ad_oe, int_oe, int_out, rmp, ind}, 8'h1f);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      tick(2);
      chk_val({4'h0, sel}, 8'h01 << m);
    end
    repeat (8) begin
      {rxp, rxn, txd} = 12'($urandom);
      tick(2);
      chk_val({txn, rxd}, {~txd, rxp & ~rxn});
      chk_val({4'h0, txp}, {4'h0, txd});
    end
    repeat (6) begin
      a = 8'h80 | 8'($urandom);
      d = 8'($urandom);
      host.write(a, d);
      mem[a] = d;
    end
    foreach (mem[k]) begin
      host.read(8'(k), d);
      chk_val(d, 8'(mem[k]));
    end
    chk_val({7'h0, ad_oe}, 8'h00);
    mask = 4;
    host.write(8'h02, 8'h04);
    host.write(8'h01, 8'hff);
    event_in(8'h02);
    event_in(8'h04);
    tick(20);
    chk_val({7'h0, int_oe}, 8'h01);
    host.read(8'h01, d);
    chk_val(d, 8'(stat));
    stat = 0;
    chk_val({7'h0, int_oe}, 8'h00);
    host.read(8'h01, d);
    chk_val(d, 8'h00);
    p = $urandom_range(0, 3);
    psel = p;
    pulse(4'h1 << p | 4'h1 << (p ^ 1), 4'h1 << p, 4'h0);
    chk_val({7'h0, ind[p ^ 1]}, 8'h01);
    measure(n);
    chk_len(n, 223);
    host.write(8'h40, 8'h02);
    psel = 4;
    lens = '{0, 1, $urandom_range(2, 20)};
    foreach (lens[i]) begin
      host.write(8'h41, 8'(lens[i]));
      pulse(4'h0, 4'h0, 4'h2);
      chk_val({7'h0, rmp}, 8'h01);
      pulse(4'h0, 4'h0, 4'h4);
      measure(n);
      chk_len(n, (lens[i] == 0) ? 1 : lens[i]);
    end
    pulse(4'h1, 4'h1, 4'h4);
    tick(2);
    rstn = 1'b0;
    #1;
    chk_val({ad_oe, int_oe, int_out, rmp, ind}, 8'h1f);
    tick(2);
    rstn = 1'b1;
    tick(2);
    host.read(8'h41, d);
    chk_val(d, 8'h08);
    host.read(8'h40, d);
    chk_val(d, 8'h00);
    host.read(8'h02, d);
    chk_val(d, 8'h00);
    tally_and_finish();
  end
endmodule
